// >>> inc/ppslc_defines.vh
// ppslc_defines.vh - offsets, field positions and reset values for the port
// device status and link capabilities registers. assumes no other header.
`ifndef PPSLC_DEFINES_VH
`define PPSLC_DEFINES_VH

// register byte offsets in configuration space
`define PPSLC_OFF_DEVSTS 12'h0c8
`define PPSLC_OFF_LINKCAP 12'h0cc

// device status field positions (upper half of the c8h dword)
`define PPSLC_BIT_CORR 16
`define PPSLC_BIT_NONFATAL 17
`define PPSLC_BIT_FATAL 18
`define PPSLC_BIT_UNSUP 19
`define PPSLC_BIT_AUXPWR 20
`define PPSLC_BIT_TRPEND 21

// link capabilities field positions
`define PPSLC_SPEED_LSB 0
`define PPSLC_WIDTH_LSB 4
`define PPSLC_ASPM_LSB 10
`define PPSLC_L0S_LSB 12
`define PPSLC_L1_LSB 15
`define PPSLC_BIT_CLKPM 18
`define PPSLC_BIT_SDOWN 19
`define PPSLC_BIT_DLLA 20
`define PPSLC_PORTNUM_LSB 24

// reset values
`define PPSLC_RST_SPEED 4'h2
`define PPSLC_RST_WIDTH 6'h01
`define PPSLC_RST_ASPM 2'h3
`define PPSLC_RST_L0S 3'h3
`define PPSLC_RST_L1 3'h0
`define PPSLC_RST_AUXPWR 1'b1
`define PPSLC_ZERO_BIT 1'b0
`define PPSLC_ONE_BIT 1'b1
`define PPSLC_ZERO8 8'h00
`define PPSLC_PAD6 6'h00
`define PPSLC_ZERO32 32'h0000_0000
`define PPSLC_ZERO4 4'h0

// loader field select codes
`define PPSLC_LD_ASPM 3'h0
`define PPSLC_LD_L0S 3'h1
`define PPSLC_LD_L1 3'h2
`define PPSLC_LD_CLKPM 3'h3
`define PPSLC_LD_PORTNUM 3'h4

`endif

// >>> verilog/ppslc_err_flags.v
// ppslc_err_flags.v - four sticky error detected flags, write one to clear.
// assumes detect pulses and the clear write are synchronous to clk.
`timescale 1ns/10ps
`include "ppslc_defines.vh"

module ppslc_err_flags (
   clk,
   rstn,
   det_pulse,
   clr_mask,
   flags_r
);
   input wire clk;
   input wire rstn;
   input wire [3:0] det_pulse;
   input wire [3:0] clr_mask;
   output reg [3:0] flags_r;

   wire [3:0] flags_nxt;

   // set wins over clear so an error arriving with the clear is kept
   assign flags_nxt = (flags_r & ~clr_mask) | det_pulse; // R18

   // flags never look at the reporting enables, they log unconditionally
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_r <= `PPSLC_ZERO4; // R1
      end else begin
         flags_r <= flags_nxt; // R5
      end
   end
endmodule // ppslc_err_flags

// >>> verilog/ppslc_regs.v
// ppslc_regs.v - device status and link capabilities registers of one port.
// assumes a simple synchronous config access port: dword address, byte
// enables, one-cycle write strobe; read data is registered one cycle later.
// Behaviour
// R1 - correctable error flag, write one clears
// R2 - non-fatal error flag, write one clears
// R3 - fatal error flag, write one clears
// R4 - unsupported request flag, write one clears
// R5 - flags log regardless of reporting enables
// R6 - aux power present reads one
// R7 - transactions pending always zero
// R8 - max link speed code, reset 0010b
// R9 - max link width, reset x1
// R10 - aspm support reset 11b
// R11 - l0s exit latency reset 011b
// R12 - l1 exit latency reset 000b
// R13 - clock pm one on upstream only
// R14 - surprise down one on downstream only
// R15 - dll active reporting always zero
// R16 - port number resets to port index
// R17 - loader may overwrite selected defaults
// R18 - detect pulse sets flag next edge
`timescale 1ns/10ps
`include "ppslc_defines.vh"

module ppslc_regs (
   clk,
   rstn,
   is_upstream,
   port_index,
   cfg_addr,
   cfg_wr,
   cfg_rd,
   cfg_be,
   cfg_wdata,
   cfg_rdata,
   cfg_rvalid,
   err_corr,
   err_nonfatal,
   err_fatal,
   err_unsup,
   ld_wr,
   ld_sel,
   ld_data
);
   // clock and asynchronous active low reset
   input wire clk;
   input wire rstn;

   // identity straps; they must be steady from reset release onwards
   input wire is_upstream;
   input wire [1:0] port_index;

   // configuration access port, one access per strobe
   input wire [11:0] cfg_addr;
   input wire cfg_wr;
   input wire cfg_rd;
   input wire [3:0] cfg_be;
   input wire [31:0] cfg_wdata;
   output reg [31:0] cfg_rdata;
   output reg cfg_rvalid;

   // one-cycle detect pulses from the port error logic
   input wire err_corr;
   input wire err_nonfatal;
   input wire err_fatal;
   input wire err_unsup;

   // default loader strobe, field select and data
   input wire ld_wr;
   input wire [2:0] ld_sel;
   input wire [7:0] ld_data;

   wire [3:0] flags;
   wire [3:0] clr_mask;
   wire hit_sts;
   wire hit_cap;
   wire ld_ok;
   wire ld_aspm;
   wire ld_l0s;
   wire ld_l1;
   wire ld_clkpm;
   wire ld_portnum;
   reg [1:0] aspm_r;
   reg [1:0] aspm_nxt;
   reg [2:0] l0s_r;
   reg [2:0] l0s_nxt;
   reg [2:0] l1_r;
   reg [2:0] l1_nxt;
   reg clkpm_r;
   reg clkpm_nxt;
   reg sdown_r;
   reg sdown_nxt;
   reg [7:0] portnum_r;
   reg [7:0] portnum_nxt;
   reg strap_done_r;
   reg [31:0] sts_word;
   reg [31:0] cap_word;
   reg [31:0] rdata_nxt;

   // dword decode; low two bits are byte lanes, selected by cfg_be
   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a[11:2] == off[11:2]);
      end
   endfunction

   // loader field decode, shared by the five loadable fields
   function ld_hit;
      input en;
      input [2:0] sel;
      input [2:0] code;
      begin
         ld_hit = en && (sel == code);
      end
   endfunction

   // the two mapped dwords
   assign hit_sts = hit(cfg_addr, `PPSLC_OFF_DEVSTS);
   assign hit_cap = hit(cfg_addr, `PPSLC_OFF_LINKCAP);

   // write one to clear, only through byte lane 2 which holds bits 23:16
   assign clr_mask = (cfg_wr && hit_sts && cfg_be[2]) ?
                     cfg_wdata[`PPSLC_BIT_UNSUP:`PPSLC_BIT_CORR] : `PPSLC_ZERO4; // R1 R2 R3 R4

   // sticky flags, a detect pulse beats a same-cycle clear
   ppslc_err_flags u_flags (
      .clk(clk),
      .rstn(rstn),
      .det_pulse({err_unsup, err_fatal, err_nonfatal, err_corr}), // R18
      .clr_mask(clr_mask),
      .flags_r(flags)
   );

   // the loader is heard only after the strap cycle, so a load never races
   // the strap capture; a load in the strap cycle is dropped silently
   assign ld_ok = ld_wr && strap_done_r;
   assign ld_aspm = ld_hit(ld_ok, ld_sel, `PPSLC_LD_ASPM); // R17
   assign ld_l0s = ld_hit(ld_ok, ld_sel, `PPSLC_LD_L0S); // R17
   assign ld_l1 = ld_hit(ld_ok, ld_sel, `PPSLC_LD_L1); // R17
   assign ld_clkpm = ld_hit(ld_ok, ld_sel, `PPSLC_LD_CLKPM); // R17
   assign ld_portnum = ld_hit(ld_ok, ld_sel, `PPSLC_LD_PORTNUM); // R17

   // aspm support; config writes never reach it, only the loader does
   always @* begin
      aspm_nxt = aspm_r;
      if (ld_aspm) begin
         aspm_nxt = ld_data[1:0]; // R17
      end
   end

   // aspm support flop, reset default
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aspm_r <= `PPSLC_RST_ASPM; // R10
      end else begin
         aspm_r <= aspm_nxt;
      end
   end

   // l0s exit latency code, loader only
   always @* begin
      l0s_nxt = l0s_r;
      if (ld_l0s) begin
         l0s_nxt = ld_data[2:0]; // R17
      end
   end

   // l0s exit latency flop, reset default
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         l0s_r <= `PPSLC_RST_L0S; // R11
      end else begin
         l0s_r <= l0s_nxt;
      end
   end

   // l1 exit latency code, loader only
   always @* begin
      l1_nxt = l1_r;
      if (ld_l1) begin
         l1_nxt = ld_data[2:0]; // R17
      end
   end

   // l1 exit latency flop, reset default
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         l1_r <= `PPSLC_RST_L1; // R12
      end else begin
         l1_r <= l1_nxt;
      end
   end

   // clock pm: strap first, loader after; a load survives until reset
   always @* begin
      clkpm_nxt = clkpm_r;
      if (!strap_done_r) begin
         clkpm_nxt = is_upstream; // R13
      end else if (ld_clkpm) begin
         clkpm_nxt = ld_data[0]; // R17
      end
   end

   // async reset may only load constants, the strap lands one edge later
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clkpm_r <= `PPSLC_ZERO_BIT;
      end else begin
         clkpm_r <= clkpm_nxt;
      end
   end

   // surprise down only means something below a downstream port; fixed
   always @* begin
      sdown_nxt = sdown_r;
      if (!strap_done_r) begin
         sdown_nxt = ~is_upstream; // R14
      end
   end

   // surprise down flop, strap caught at the first edge after reset
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdown_r <= `PPSLC_ZERO_BIT;
      end else begin
         sdown_r <= sdown_nxt;
      end
   end

   // port number: strap index zero extended, loader may replace it
   always @* begin
      portnum_nxt = portnum_r;
      if (!strap_done_r) begin
         portnum_nxt = {`PPSLC_PAD6, port_index}; // R16
      end else if (ld_portnum) begin
         portnum_nxt = ld_data; // R17
      end
   end

   // port number flop, strap caught at the first edge after reset
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         portnum_r <= `PPSLC_ZERO8;
      end else begin
         portnum_r <= portnum_nxt;
      end
   end

   // strap cycle marker, high from the first edge after reset onwards
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_done_r <= `PPSLC_ZERO_BIT;
      end else begin
         strap_done_r <= `PPSLC_ONE_BIT;
      end
   end

   // status word, upper half of the c8h dword:
   //   19:16 sticky flags: unsupported, fatal, non-fatal, correctable
   //   20 aux power present, reads one from reset on
   //   21 transactions pending, tied low, the port has no own requests
   //   31:22 and 15:0 read zero; the lower half is device control,
   //   which lives outside this block
   always @* begin
      sts_word = `PPSLC_ZERO32;
      sts_word[`PPSLC_BIT_UNSUP:`PPSLC_BIT_CORR] = flags; // R1 R2 R3 R4
      sts_word[`PPSLC_BIT_AUXPWR] = `PPSLC_RST_AUXPWR; // R6
      sts_word[`PPSLC_BIT_TRPEND] = `PPSLC_ZERO_BIT; // R7
   end

   // link capabilities word at cch:
   //   3:0 speed and 9:4 width are fixed codes, never loadable
   //   11:10 aspm, 14:12 l0s and 17:15 l1 latency come from loadable flops
   //   18 clock pm and 19 surprise down are strap derived, only 18 loads
   //   20 dll active reporting reads zero on every port
   //   23:21 reserved zero, 31:24 port number
   always @* begin
      cap_word = `PPSLC_ZERO32;
      cap_word[`PPSLC_SPEED_LSB+3:`PPSLC_SPEED_LSB] = `PPSLC_RST_SPEED; // R8
      cap_word[`PPSLC_WIDTH_LSB+5:`PPSLC_WIDTH_LSB] = `PPSLC_RST_WIDTH; // R9
      cap_word[`PPSLC_ASPM_LSB+1:`PPSLC_ASPM_LSB] = aspm_r; // R10
      cap_word[`PPSLC_L0S_LSB+2:`PPSLC_L0S_LSB] = l0s_r; // R11
      cap_word[`PPSLC_L1_LSB+2:`PPSLC_L1_LSB] = l1_r; // R12
      cap_word[`PPSLC_BIT_CLKPM] = clkpm_r; // R13
      cap_word[`PPSLC_BIT_SDOWN] = sdown_r; // R14
      cap_word[`PPSLC_BIT_DLLA] = `PPSLC_ZERO_BIT; // R15
      cap_word[`PPSLC_PORTNUM_LSB+7:`PPSLC_PORTNUM_LSB] = portnum_r; // R16
   end

   // read mux; unmapped dwords read zero rather than aliasing
   always @* begin
      if (hit_sts) begin
         rdata_nxt = sts_word;
      end else if (hit_cap) begin
         rdata_nxt = cap_word;
      end else begin
         rdata_nxt = `PPSLC_ZERO32;
      end
   end

   // read valid pulse, exactly one cycle after the accepted strobe
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rvalid <= `PPSLC_ZERO_BIT;
      end else begin
         cfg_rvalid <= cfg_rd;
      end
   end

   // read data holds between reads, so a slow host may pick it up late
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata <= `PPSLC_ZERO32;
      end else if (cfg_rd) begin
         cfg_rdata <= rdata_nxt;
      end
   end
endmodule // ppslc_regs

// >>> bench/ppslc_regs_properties.sv
// ppslc_regs_properties.sv - port checks of the status and caps words.
// assumes bind to ppslc_regs; straps only change while rstn is low.
`timescale 1ns/10ps
module ppslc_regs_properties (
   input wire clk,
   input wire rstn,
   input wire is_upstream,
   input wire [1:0] port_index,
   input wire [11:0] cfg_addr,
   input wire cfg_wr,
   input wire cfg_rd,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   input wire [31:0] cfg_rdata,
   input wire cfg_rvalid,
   input wire err_corr,
   input wire err_nonfatal,
   input wire err_fatal,
   input wire err_unsup,
   input wire ld_wr,
   input wire [2:0] ld_sel,
   input wire [7:0] ld_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // dword decode, low two address bits ignored
   wire st_rd = cfg_rd && cfg_addr[11:2] == 10'h032;
   wire cp_rd = cfg_rd && cfg_addr[11:2] == 10'h033;
   chk_rvalid_follow: assert property (cfg_rd |=> cfg_rvalid) else $error("read valid missing");
   chk_rvalid_alone: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray read valid");
   chk_aux_pend: assert property (st_rd |=> cfg_rdata[21:20] == 2'h1)
      else $error("aux or pending bit wrong");
   chk_speed_width: assert property (cp_rd |=> cfg_rdata[9:0] == 10'h012)
      else $error("speed or width wrong");
   chk_dlla_zero: assert property (cp_rd |=> cfg_rdata[23:20] == 4'h0)
      else $error("dll active bit set");
   chk_sdown_strap: assert property (cp_rd |=> cfg_rdata[19] == !is_upstream)
      else $error("surprise down wrong");
   chk_fatal_sticky: assert property (err_fatal ##1 (st_rd && !cfg_wr) |=> cfg_rdata[18])
      else $error("fatal flag not set");
   chk_corr_sticky: assert property (err_corr ##1 (st_rd && !cfg_wr) |=> cfg_rdata[16])
      else $error("correctable flag not set");
   // main traffic seen
   cov_clear: cover property (cfg_wr && cfg_be[2]);
   cov_load: cover property (ld_wr && ld_sel == 3'h4);
   cov_unsup: cover property (err_unsup ##1 st_rd);
endmodule // ppslc_regs_properties

// >>> bench/ppslc_cfg_host.sv
// ppslc_cfg_host.sv - configuration software model, one access per call.
// assumes calls start just after a falling edge of clk.
`timescale 1ns/10ps
module ppslc_cfg_host (
   input wire clk,
   output logic [11:0] cfg_addr,
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire [31:0] cfg_rdata
);
   initial {cfg_addr, cfg_wr, cfg_rd, cfg_be, cfg_wdata} = '0;
   // idle address and write data show inverted values so stale data never passes
   task acc(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd,
            output logic [31:0] d);
      begin
         {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, be, wd};
         @(negedge clk);
         d = cfg_rdata;
         {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b00, ~a, ~wd};
         @(negedge clk);
      end
   endtask
endmodule // ppslc_cfg_host

// >>> bench/tb_top.sv
// tb_top.sv - random errors, loads and clears checked against a model.
// assumes ppslc_regs, ppslc_cfg_host and the checker are compiled first.
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0, rstn = 1'b0, is_upstream = 1'b0, ld_wr = 1'b0;
   logic [1:0] port_index = 2'h0;
   logic [3:0] err = 4'h0;
   logic [2:0] ld_sel = 3'h0;
   logic [7:0] ld_data = 8'h00;
   logic [31:0] seed = 32'hd684_209f, d;
   int errors = 0, checks_done = 0, flags, aspm, l0s, l1, clkpm, pnum;
   wire [11:0] cfg_addr;
   wire cfg_wr, cfg_rd, cfg_rvalid;
   wire [3:0] cfg_be;
   wire [31:0] cfg_wdata, cfg_rdata;
   ppslc_regs ppslc_regs_i (.clk, .rstn, .is_upstream, .port_index, .cfg_addr, .cfg_wr,
      .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .err_corr(err[0]),
      .err_nonfatal(err[1]), .err_fatal(err[2]), .err_unsup(err[3]), .ld_wr, .ld_sel, .ld_data);
   ppslc_cfg_host ppslc_cfg_host_i (.clk, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
      .cfg_rdata);
   always #5 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task cmp(input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("ERROR %0t exp %h got %h", $time, e, g);
         errors++;
      end
   endtask
   task stop_test;
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // reset with new straps; model restarts from the reset values
   task do_reset(input logic up, input logic [1:0] pi);
      {rstn, is_upstream, port_index} = {1'b0, up, pi};
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      {flags, aspm, l0s, l1, clkpm, pnum} = {32'd0, 32'd3, 32'd3, 32'd0, 31'd0, up, 30'd0, pi};
   endtask
   task chk_both;
      ppslc_cfg_host_i.acc(1'b0, 12'h0c8, 4'hf, seed, d);
      cmp({10'h000, 2'h1, flags[3:0], 16'h0000}, d);
      ppslc_cfg_host_i.acc(1'b0, 12'h0cc, 4'hf, seed, d);
      cmp({pnum[7:0], 4'h0, !is_upstream, clkpm[0], l1[2:0], l0s[2:0], aspm[1:0], 10'h012},
         d);
   endtask
   // two strap rounds; each step pulses errors and a load, then clears
   initial begin
      for (int k = 0; k < 2; k++) begin
         seed = xs(seed);
         do_reset(seed[0], seed[2:1]);
         chk_both();
         ppslc_cfg_host_i.acc(1'b0, 12'h0d0, 4'hf, seed, d);
         cmp(32'h0000_0000, d);
         for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            {ld_data, ld_sel, ld_wr, err} = seed[15:0];
            @(negedge clk);
            {err, ld_wr} = 5'h00;
            flags |= seed[3:0];
            if (seed[4]) begin
               case (seed[7:5])
                  3'h0: aspm = seed[9:8];
                  3'h1: l0s = seed[10:8];
                  3'h2: l1 = seed[10:8];
                  3'h3: clkpm = seed[8];
                  3'h4: pnum = seed[15:8];
                  default: ;
               endcase
            end
            ppslc_cfg_host_i.acc(1'b0, 12'h0c8, 4'hf, seed, d);
            cmp({10'h000, 2'h1, flags[3:0], 16'h0000}, d);
            ppslc_cfg_host_i.acc(1'b1, seed[24] ? 12'h0cc : 12'h0c8, seed[23:20], seed, d);
            if (!seed[24] && seed[22]) flags &= ~seed[19:16];
            chk_both();
         end
      end
      stop_test();
   end
   // hang guard; a clean run takes under a thousand cycles, this allows 5000
   initial begin
      #50000;
      errors++;
      stop_test();
   end
endmodule // tb_top
bind ppslc_regs ppslc_regs_properties ppslc_regs_properties_i (.clk, .rstn, .is_upstream,
   .port_index, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
   .err_corr, .err_nonfatal, .err_fatal, .err_unsup, .ld_wr, .ld_sel, .ld_data);
